// ==== src/mcu_sysctl_params.svh ====
// timing counts, offsets, field positions and reset values of the system control block
`ifndef MCU_SYSCTL_PARAMS_SVH
`define MCU_SYSCTL_PARAMS_SVH
`define PCLK_PS         8000
`define RST_FILT_NS     40
`define RST_FILT_CYC    ((`RST_FILT_NS * 1000 + `PCLK_PS - 1) / `PCLK_PS)
`define RST_SAMPLES     2'h2
`define OFF_POWER_CONTROL_REGISTER        8'h00
`define OFF_SP          8'h04
`define OFF_PORTS       8'h08
`define OFF_SERIAL_BUFFER        8'h0c
`define OFF_BUS         8'h10
`define OFF_STAT        8'h14
`define POWER_CONTROL_REGISTER_IDLE       0
`define POWER_CONTROL_REGISTER_PD         1
`define POWER_CONTROL_REGISTER_KEEP_MASK  8'h10
`define PORT_RST        8'hff
`define SP_RST          8'h07
`define BUS_GO          31
`define SLOT_LAST       4'hb
`define SLOT_ADDR_LAST  4'h2
`define SLOT_ALE_A      4'h1
`define SLOT_ALE_B      4'h7
`define SLOT_PROGRAM_STORE_STROBE_FIRST 4'h3
`define SLOT_PROGRAM_STORE_STROBE_LAST  4'h5
`define SLOT_WDATA      4'h5
`define SLOT_STRB       4'h6
`define SLOT_RST        4'h9
`endif

// ==== src/mcu_sysctl_pkg.sv ====
// types shared by the system control block
package mcu_sysctl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WAIT  = 3'b010,
      ST_CYCLE = 3'b100
   } bus_state_t;
   typedef enum logic [1:0] {
      KIND_FETCH = 2'h0,
      KIND_CODE  = 2'h1,
      KIND_DRD   = 2'h2,
      KIND_DWR   = 2'h3
   } bus_kind_t;
   typedef struct packed {
      bus_kind_t   kind;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } bus_req_t;
endpackage

// ==== src/mcu_sysctl.sv ====
// clock division, power modes, reset sampling and external bus strobes
`timescale 1ns/10ps
`include "mcu_sysctl_params.svh"
module mcu_sysctl
   import mcu_sysctl_pkg::*;
(
   input  wire logic        pclk,            // system clock 125 MHz
   input  wire logic        presetn,         // power-on reset, async
   input  wire logic        psel,            // apb select
   input  wire logic        penable,         // apb enable
   input  wire logic        pwrite,          // apb direction
   input  wire logic [7:0]  paddr,           // apb byte address
   input  wire logic [31:0] pwdata,          // apb write data
   output logic      [31:0] prdata,          // apb read data
   output logic             pready,          // apb ready
   output logic             pslverr,         // apb error
   input  wire logic        osc_in,          // oscillator input pin
   input  wire logic        rst_in,          // reset pin, active high
   input  wire logic        fetch_sel_n,     // external fetch select pin
   input  wire logic        irq_wake,        // interrupt taken
   input  wire logic [7:0]  low_port_in,     // low port pin level
   output logic      [7:0]  low_port_out,    // low port drive value
   output logic             low_port_oe_n,   // low port drive enable
   output logic      [7:0]  high_port_out,   // high address port
   output logic             ale_out,         // address latch strobe
   output logic             ale_oe_n,        // latch strobe drive enable
   output logic             program_store_strobe_n_out,      // program store strobe
   output logic             program_store_strobe_oe_n,       // program strobe drive enable
   output logic             wr_strobe_n,     // data write strobe
   output logic             rd_strobe_n,     // data read strobe
   output logic             core_clk_en,     // core clock enable pulse
   output logic             periph_clk_en,   // peripheral clock enable pulse
   output logic             in_reset         // device held in reset
);

   // synchronisers; stage 0 feeds only stage 1
   logic [2:0]       osc_sync_r;
   logic [1:0]       rst_sync_r;
   logic [1:0]       ea_sync_r;
   logic [7:0]       low_s0_r;
   logic [7:0]       low_s1_r;
   logic [3:0]       slot_r;
   logic [2:0]       filt_cnt_r;
   logic             rst_filt_r;
   logic [1:0]       rst_cnt_r;
   logic             in_reset_r;
   logic [7:0]       power_control_register_r;
   logic [7:0]       power_control_register_nxt;
   logic [7:0]       sp_r;
   logic [7:0]       port_r [0:3];
   logic [7:0]       serial_buffer_r;
   bus_state_t       state_r;
   bus_state_t       state_nxt;
   bus_req_t         req_r;
   logic [7:0]       rdata_r;
   logic             fetch_err_r;
   logic             pready_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_sync_r <= 3'h0;
         rst_sync_r <= 2'h0;
         ea_sync_r  <= 2'h0;
         low_s0_r   <= 8'h00;
         low_s1_r   <= 8'h00;
      end else begin
         osc_sync_r <= {osc_sync_r[1:0], osc_in};
         rst_sync_r <= {rst_sync_r[0], rst_in};
         ea_sync_r  <= {ea_sync_r[0], fetch_sel_n};
         low_s0_r   <= low_port_in;
         low_s1_r   <= low_s0_r;
      end
   end

   // one tick per oscillator rise outside power-down; a halted oscillator simply stops ticks
   wire osc_tick  = osc_sync_r[1] & ~osc_sync_r[2] & ~power_control_register_r[`POWER_CONTROL_REGISTER_PD];
   wire slot_end  = slot_r == `SLOT_LAST;
   wire cyc_end   = osc_tick & slot_end;
   wire rst_smp   = osc_tick & (slot_r == `SLOT_RST);

   // twelve oscillator phases per machine cycle, held while stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_r <= 4'h0;
      end else if (osc_tick) begin
         slot_r <= slot_end ? 4'h0 : slot_r + 4'h1;
      end
   end

   // deglitch: level must stand for the filter time before it counts
   wire filt_done = filt_cnt_r == 3'(`RST_FILT_CYC - 1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_cnt_r <= 3'h0;
         rst_filt_r <= 1'b0;
      end else if (rst_sync_r[1] == rst_filt_r) begin
         filt_cnt_r <= 3'h0;
      end else if (filt_done) begin
         filt_cnt_r <= 3'h0;
         rst_filt_r <= rst_sync_r[1];
      end else begin
         filt_cnt_r <= filt_cnt_r + 3'h1;
      end
   end

   // two consecutive late-phase samples high before reset takes hold
   wire [1:0] rst_cnt_inc = (rst_cnt_r == `RST_SAMPLES) ? rst_cnt_r : rst_cnt_r + 2'h1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cnt_r  <= 2'h0;
         in_reset_r <= 1'b0;
      end else if (rst_smp) begin
         rst_cnt_r  <= rst_filt_r ? rst_cnt_inc : 2'h0;
         in_reset_r <= rst_filt_r & (rst_cnt_inc == `RST_SAMPLES);
      end
   end

   // apb decode; each access waits one cycle so read data is registered
   wire acc      = psel & penable & pready_r;
   wire sel_power_control_register = paddr == `OFF_POWER_CONTROL_REGISTER;
   wire sel_sp   = paddr == `OFF_SP;
   wire sel_port = paddr == `OFF_PORTS;
   wire sel_serial_buffer = paddr == `OFF_SERIAL_BUFFER;
   wire sel_bus  = paddr == `OFF_BUS;
   wire sel_stat = paddr == `OFF_STAT;
   wire hit      = sel_power_control_register | sel_sp | sel_port | sel_serial_buffer | sel_bus | sel_stat;
   wire wr_acc   = acc & pwrite;
   wire [31:0] stat_word = {16'h0000, rdata_r, 2'h0, fetch_err_r, ea_sync_r[1],
                            power_control_register_r[`POWER_CONTROL_REGISTER_PD], power_control_register_r[`POWER_CONTROL_REGISTER_IDLE], in_reset_r,
                            state_r != ST_IDLE};
   wire [31:0] port_word = {port_r[3], port_r[2], port_r[1], port_r[0]};
   wire [31:0] rd_mux = sel_power_control_register ? {24'h00_0000, power_control_register_r} :
                        sel_sp   ? {24'h00_0000, sp_r} :
                        sel_port ? port_word :
                        sel_serial_buffer ? {24'h00_0000, serial_buffer_r} :
                        sel_bus  ? {6'h00, req_r} :
                        sel_stat ? stat_word : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         prdata   <= 32'h0000_0000;
         pslverr  <= 1'b0;
      end else begin
         pready_r <= psel & penable & ~pready_r;
         prdata   <= rd_mux;
         pslverr  <= psel & penable & ~pready_r & ~hit;
      end
   end
   assign pready = pready_r;

   // power control: interrupt ends idle, filtered reset ends power-down
   always_comb begin
      power_control_register_nxt = power_control_register_r;
      if (irq_wake) power_control_register_nxt[`POWER_CONTROL_REGISTER_IDLE] = 1'b0;
      if (rst_filt_r) power_control_register_nxt[`POWER_CONTROL_REGISTER_PD] = 1'b0;
      if (wr_acc & sel_power_control_register) power_control_register_nxt = pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_control_register_r <= 8'h00;
      end else if (in_reset_r) begin
         power_control_register_r <= power_control_register_r & `POWER_CONTROL_REGISTER_KEEP_MASK;
      end else begin
         power_control_register_r <= power_control_register_nxt;
      end
   end

   // stack pointer and serial buffer; serial buffer ignores pin reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_r   <= `SP_RST;
         serial_buffer_r <= 8'h00;
      end else begin
         if (in_reset_r) sp_r <= `SP_RST;
         else if (wr_acc & sel_sp) sp_r <= pwdata[7:0];
         if (wr_acc & sel_serial_buffer) serial_buffer_r <= pwdata[7:0];
      end
   end

   // port latches, all ones after either reset
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_port
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               port_r[gi] <= `PORT_RST;
            end else if (in_reset_r) begin
               port_r[gi] <= `PORT_RST;
            end else if (wr_acc & sel_port) begin
               port_r[gi] <= pwdata[8*gi +: 8];
            end
         end
      end
   endgenerate

   // bus request: fetch kinds refused unless fetch select is low
   wire       go_wr   = wr_acc & sel_bus & pwdata[`BUS_GO] & (state_r == ST_IDLE);
   wire       go_prog = pwdata[25:24] == KIND_FETCH || pwdata[25:24] == KIND_CODE;
   wire       go_ok   = go_wr & ~in_reset_r & ~(go_prog & ea_sync_r[1]);
   wire       in_cyc  = state_r == ST_CYCLE;
   wire       is_prog = req_r.kind == KIND_FETCH || req_r.kind == KIND_CODE;
   wire       is_rd   = req_r.kind == KIND_DRD;
   wire       is_wr   = req_r.kind == KIND_DWR;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:  if (go_ok) state_nxt = ST_WAIT;
         ST_WAIT:  if (cyc_end) state_nxt = ST_CYCLE;
         ST_CYCLE: if (cyc_end) state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
      if (in_reset_r) state_nxt = ST_IDLE;
   end

   // capture points: end of program strobe, end of read strobe
   wire cap_prog = in_cyc & is_prog & osc_tick & (slot_r == `SLOT_PROGRAM_STORE_STROBE_LAST);
   wire cap_rd   = in_cyc & is_rd & cyc_end;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r     <= ST_IDLE;
         req_r       <= '0;
         rdata_r     <= 8'h00;
         fetch_err_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (go_ok) req_r <= {bus_kind_t'(pwdata[25:24]), pwdata[15:0], pwdata[23:16]};
         if (cap_prog | cap_rd) rdata_r <= low_s1_r;
         if (go_wr & go_prog & ea_sync_r[1]) fetch_err_r <= 1'b1;
         else if (go_ok) fetch_err_r <= 1'b0;
      end
   end

   // strobe timing from the phase slot
   wire in_addr   = slot_r <= `SLOT_ADDR_LAST;
   wire ale_a     = slot_r == `SLOT_ALE_A || slot_r == `SLOT_ALE_A + 4'h1;
   wire ale_b     = slot_r == `SLOT_ALE_B || slot_r == `SLOT_ALE_B + 4'h1;
   wire skip_b    = in_cyc & (is_rd | is_wr);
   wire ale_nxt   = ale_a | (ale_b & ~skip_b);
   wire program_store_strobe_on   = in_cyc & is_prog & slot_r >= `SLOT_PROGRAM_STORE_STROBE_FIRST
                    & slot_r <= `SLOT_PROGRAM_STORE_STROBE_LAST;
   wire strb_on   = in_cyc & slot_r >= `SLOT_STRB;
   wire drive_lo  = in_cyc & (in_addr | (is_wr & slot_r >= `SLOT_WDATA));

   // all pin outputs registered; latch and program strobes released to the pull-up in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ale_out       <= 1'b1;
         ale_oe_n      <= 1'b1;
         program_store_strobe_n_out    <= 1'b1;
         program_store_strobe_oe_n     <= 1'b1;
         low_port_out  <= 8'h00;
         low_port_oe_n <= 1'b1;
         high_port_out <= `PORT_RST;
         wr_strobe_n   <= 1'b1;
         rd_strobe_n   <= 1'b1;
      end else begin
         ale_out       <= in_reset_r | ale_nxt;
         ale_oe_n      <= in_reset_r;
         program_store_strobe_n_out    <= ~program_store_strobe_on;
         program_store_strobe_oe_n     <= in_reset_r;
         low_port_out  <= in_addr ? req_r.addr[7:0] : req_r.wdata;
         low_port_oe_n <= ~drive_lo;
         high_port_out <= in_cyc ? req_r.addr[15:8] : port_r[2];
         wr_strobe_n   <= (strb_on & is_wr) ? 1'b0 : port_r[3][6];
         rd_strobe_n   <= (strb_on & is_rd) ? 1'b0 : port_r[3][7];
      end
   end

   // every second oscillator tick; idle gates the core only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_clk_en   <= 1'b0;
         periph_clk_en <= 1'b0;
         in_reset      <= 1'b0;
      end else begin
         core_clk_en   <= osc_tick & slot_r[0] & ~power_control_register_r[`POWER_CONTROL_REGISTER_IDLE];
         periph_clk_en <= osc_tick & slot_r[0];
         in_reset      <= in_reset_r;
      end
   end

   // checks beside the logic
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ale_weak_reset: assert property (in_reset_r |=> ale_oe_n && ale_out)
      else $error("latch strobe driven during reset");
   a_program_store_strobe_weak_reset: assert property (in_reset_r |=> program_store_strobe_oe_n && program_store_strobe_n_out)
      else $error("program strobe driven during reset");
   // the strobe's power-on reset level is no slot pulse, so skip the first edge after it
   a_ale_slot_only: assert property (ale_out && !in_reset && $past(presetn) |->
                                     $past(ale_a || ale_b))
      else $error("latch strobe outside its slots");
   a_ale_skip_data: assert property (in_cyc && ale_b && (is_rd || is_wr) |=> !ale_out)
      else $error("latch strobe not skipped in data cycle");
   a_program_store_strobe_prog_only: assert property (!program_store_strobe_n_out |-> $past(in_cyc && is_prog))
      else $error("program strobe without program cycle");
   a_high_addr_out: assert property (in_cyc |=> high_port_out == $past(req_r.addr[15:8]))
      else $error("upper address byte wrong");
   a_low_addr_out: assert property (in_cyc && in_addr |=>
                                    !low_port_oe_n && low_port_out == $past(req_r.addr[7:0]))
      else $error("low address byte not driven");
   a_rd_strobe_kind: assert property (!rd_strobe_n && !$past(in_reset_r) |->
                                      $past(is_rd || !port_r[3][7]))
      else $error("read strobe in wrong cycle");
   a_idle_stops_core: assert property (power_control_register_r[`POWER_CONTROL_REGISTER_IDLE] |=> !core_clk_en)
      else $error("core clock runs in idle");
   // one cycle only: a filtered pin reset may clear power-down in the next cycle
   a_pd_stops_all: assert property (power_control_register_r[`POWER_CONTROL_REGISTER_PD] |=> !periph_clk_en && !core_clk_en)
      else $error("clock runs in power-down");
   a_reset_loads: assert property ($rose(in_reset_r) |=> sp_r == `SP_RST && port_r[0] == `PORT_RST
                                   && !power_control_register_r[`POWER_CONTROL_REGISTER_IDLE] && !power_control_register_r[`POWER_CONTROL_REGISTER_PD])
      else $error("reset values not loaded");
   a_keep_bit4: assert property (in_reset_r |=> power_control_register_r[4] == $past(power_control_register_r[4]))
      else $error("control bit 4 lost in reset");
   a_fetch_refused: assert property (go_wr && go_prog && ea_sync_r[1] |=> state_r == ST_IDLE)
      else $error("fetch started with fetch select high");

   c_data_write: cover property (in_cyc && is_wr && !wr_strobe_n);
   c_fetch: cover property (in_cyc && is_prog && !program_store_strobe_n_out);
   c_pin_reset: cover property ($rose(in_reset_r));
   c_idle_wake: cover property (power_control_register_r[`POWER_CONTROL_REGISTER_IDLE] ##1 !power_control_register_r[`POWER_CONTROL_REGISTER_IDLE]);

endmodule

// ==== dv/ext_mem_model.sv ====
// behavioural model of the external address latch, program memory and data memory
`timescale 1ns/10ps
module ext_mem_model (
   input  wire logic       pclk,           // system clock
   input  wire logic       late,           // slow answer select
   input  wire logic [7:0] low_port_out,   // low port drive value
   input  wire logic       low_port_oe_n,  // low port drive enable
   input  wire logic [7:0] high_port_out,  // high address port
   input  wire logic       ale_pin,        // latch strobe pin level
   input  wire logic       program_store_strobe_pin,       // program strobe pin level
   input  wire logic       wr_strobe_n,    // data write strobe
   input  wire logic       rd_strobe_n,    // data read strobe
   output logic      [7:0] low_port_in     // resolved low port level
);
   logic [7:0] lat_r;
   logic [7:0] last_r = 8'h00;
   logic [1:0] wait_r = 2'h0;
   logic [7:0] dmem [0:65535];
   wire [15:0] addr = {high_port_out, lat_r};
   wire        rd_en = !program_store_strobe_pin || !rd_strobe_n;
   wire [7:0]  rdat = !program_store_strobe_pin ? addr[7:0] ^ addr[15:8] ^ 8'h3c : dmem[addr];
   // no pull-up on the low port: a released bus shows the inverse of its last level
   assign low_port_in = !low_port_oe_n ? low_port_out :
                        (rd_en && (!late || wait_r == 2'h3)) ? rdat : ~last_r;
   // transparent latch follows the port while the strobe is high, holds after it falls
   always @(posedge pclk) begin
      last_r <= low_port_in;
      if (ale_pin) lat_r <= low_port_in;
      wait_r <= !rd_en ? 2'h0 : (wait_r == 2'h3 ? wait_r : wait_r + 2'h1);
      if (!wr_strobe_n) dmem[addr] <= low_port_in;
   end
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the system control block
`timescale 1ns/10ps
module tb_top import mcu_sysctl_pkg::*;;
   logic        pclk, presetn, psel, penable, pwrite, osc_in, rst_in, fetch_sel_n;
   logic        irq_wake, late, osc_run, clr, ale_q, err, hit;
   logic [7:0]  paddr, low_port_in, low_port_out, high_port_out, d;
   logic [15:0] a;
   logic [31:0] pwdata, prdata, q, st, r, v;
   logic        pready, pslverr, low_port_oe_n, ale_out, ale_oe_n, program_store_strobe_n_out, program_store_strobe_oe_n;
   logic        wr_strobe_n, rd_strobe_n, core_clk_en, periph_clk_en, in_reset;
   logic [31:0] seed = 32'h0000_dd51;
   int          n_errors = 0, n_compared = 0, gap = 0, max_gap = 0, n_ale, n_core, n_per;
   wire         ale_pin  = ale_oe_n ? 1'b1 : ale_out;     // weak pull-up when released
   wire         program_store_strobe_pin = program_store_strobe_oe_n ? 1'b1 : program_store_strobe_n_out;

   mcu_sysctl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .osc_in, .rst_in, .fetch_sel_n, .irq_wake, .low_port_in,
      .low_port_out, .low_port_oe_n, .high_port_out, .ale_out, .ale_oe_n, .program_store_strobe_n_out,
      .program_store_strobe_oe_n, .wr_strobe_n, .rd_strobe_n, .core_clk_en, .periph_clk_en, .in_reset);
   ext_mem_model mem (.pclk, .late, .low_port_out, .low_port_oe_n, .high_port_out,
      .ale_pin, .program_store_strobe_pin, .wr_strobe_n, .rd_strobe_n, .low_port_in);

   always #4 pclk = ~pclk;
   // oscillator offset by 3 ns so its edges never meet a clock edge
   initial begin
      #3;
      forever begin
         #32;
         if (osc_run) osc_in = ~osc_in;
      end
   end
   // strobe spacing and clock enable counters, cleared per window except the running gap count
   always @(posedge pclk) begin
      ale_q <= ale_pin;
      gap <= (ale_pin && !ale_q) ? 0 : gap + 1;
      n_core <= clr ? 0 : n_core + core_clk_en;
      n_per <= clr ? 0 : n_per + periph_clk_en;
      n_ale <= clr ? 0 : n_ale + (ale_pin && !ale_q);
      if (clr) max_gap <= 0;
      else if (ale_pin && !ale_q && gap + 1 > max_gap) max_gap <= gap + 1;
   end

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic summarize();
      if (n_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one apb transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_errors++;
         summarize();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic meas(input int n);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      tick(n);
   endtask

   // issue an external cycle and poll busy with a bound
   task automatic bus(input bus_kind_t k, input logic [15:0] ba, input logic [7:0] bd);
      int i;
      apb(1'b1, 8'h10, {1'b1, 5'h00, k, bd, ba});
      for (i = 0; i < 100; i++) begin
         apb(1'b0, 8'h14, 32'h0000_0000);
         if (q[0] === 1'b0) break;
      end
      if (i == 100) begin
         n_errors++;
         summarize();
      end
      st = q;
   endtask

   task automatic rpulse(input int n);
      rst_in <= 1'b1;
      tick(n);
      cmp("reset pins", 32'h1f, {in_reset, ale_oe_n, program_store_strobe_oe_n, ale_pin, program_store_strobe_pin});
      rst_in <= 1'b0;
      tick(300);
      cmp("reset end", 32'h0, in_reset);
   endtask

   initial begin
      {pclk, presetn, psel, penable, pwrite, rst_in, fetch_sel_n, irq_wake} = 8'h00;
      {osc_in, late, clr, paddr, pwdata} = '0;
      osc_run = 1'b1;
      tick(8);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      cmp("power_control_register", 32'h0, q & 32'hffff_ffef);
      apb(1'b0, 8'h04, 32'h0);
      cmp("stack", 32'h0000_0007, q);
      apb(1'b0, 8'h08, 32'h0);
      cmp("ports", 32'hffff_ffff, q);
      apb(1'b0, 8'h18, 32'h0);
      cmp("unmapped err", 32'h1, err);
      meas(161);
      cmp("core ticks", 32'd10, n_core);
      cmp("ale gap", 32'd48, max_gap);
      // random and corner addresses over every bus kind
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         a = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : r[31:16];
         d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : r[15:8];
         late <= r[0];
         // let the pulse after the last data cycle's skipped one pass first
         tick(12);
         meas(1);
         bus(bus_kind_t'({1'b0, r[1]}), a, 8'h00);
         cmp("prog byte", {24'h0, a[7:0] ^ a[15:8] ^ 8'h3c}, st[15:8]);
         cmp("fetch gap", 32'd48, max_gap);
         meas(1);
         bus(KIND_DWR, a, d);
         cmp("mem write", {24'h0, d}, mem.dmem[a]);
         bus(KIND_DRD, a, 8'h00);
         cmp("data read", {24'h0, d}, st[15:8]);
         cmp("data gap", 32'd96, max_gap);
      end
      // idle: core stops, peripherals run, interrupt resumes
      apb(1'b1, 8'h00, 32'h0000_0001);
      meas(161);
      cmp("idle core", 32'd0, n_core);
      cmp("idle periph", 32'd10, n_per);
      irq_wake <= 1'b1;
      tick(1);
      irq_wake <= 1'b0;
      apb(1'b0, 8'h00, 32'h0);
      cmp("idle bit", 32'h0, q[0]);
      meas(161);
      cmp("woken core", 32'd10, n_core);
      // power-down: only pin reset wakes; bit 4 and serial buffer survive
      v = rnd() & 32'h0000_00ff;
      apb(1'b1, 8'h0c, v);
      apb(1'b1, 8'h04, 32'h0000_0033);
      apb(1'b1, 8'h08, rnd() | 32'hc000_0000);
      apb(1'b1, 8'h00, 32'h0000_0013);
      meas(161);
      cmp("pd clocks", 32'd0, n_per + n_core);
      irq_wake <= 1'b1;
      tick(1);
      irq_wake <= 1'b0;
      meas(161);
      cmp("pd irq", 32'd0, n_per);
      rpulse(400);
      apb(1'b0, 8'h00, 32'h0);
      cmp("power_control_register after", 32'h0000_0010, q);
      apb(1'b0, 8'h04, 32'h0);
      cmp("stack after", 32'h0000_0007, q);
      apb(1'b0, 8'h08, 32'h0);
      cmp("ports after", 32'hffff_ffff, q);
      apb(1'b0, 8'h0c, 32'h0);
      cmp("serial_buffer kept", v, q);
      // short spike on the reset pin must be ignored
      rst_in <= 1'b1;
      tick(3);
      rst_in <= 1'b0;
      hit = 1'b0;
      repeat (300) @(posedge pclk) hit |= in_reset;
      cmp("glitch", 32'h0, hit);
      // oscillator halted high for a long time, state kept
      v = rnd() & 32'h0000_00ff;
      apb(1'b1, 8'h04, v);
      @(posedge osc_in);
      @(posedge pclk);
      osc_run <= 1'b0;
      // the last rise still needs its synchroniser and output stage
      tick(4);
      meas(400);
      cmp("halted", 32'd0, n_ale + n_per);
      osc_run <= 1'b1;
      apb(1'b0, 8'h04, 32'h0);
      cmp("stack kept", v, q);
      meas(161);
      cmp("resumed", 32'd10, n_per);
      // external fetch select high: fetch refused and flagged
      fetch_sel_n <= 1'b1;
      tick(4);
      bus(KIND_FETCH, 16'h1234, 8'h00);
      cmp("fetch refused", 32'h1, st[5]);
      fetch_sel_n <= 1'b0;
      summarize();
   end
endmodule
